// *** async_timer_domain_sync_tb.sv ***
// Self-checking bench for the asynchronous timer crossing block
`timescale 1ns/1ps
`include "atd_map.svh"
module async_timer_domain_sync_tb
  import atd_pkg::*;
;
  logic       core_clk, rst_b, sleepReq, deepSleep, asyncSel, oscIn;
  logic       cmpFlag, ovfFlag, cmpOut, oscEn, stall, wake, prevOut;
  logic       sawOvf;
  atd_write_s cpuWrite;
  atd_busy_s  busy;
  atd_byte_t  cnt;
  int         num_errors, samples_checked, n;

  atd_async_timer uut (.core_clk(core_clk), .rst_b(rst_b),
    .cpuWrite(cpuWrite), .sleepReq(sleepReq), .deepSleep(deepSleep),
    .timerOscInput(oscIn), .asyncClockSelect(asyncSel),
    .asyncStatusRegister(busy), .timerCountRead(cnt),
    .compareFlag(cmpFlag), .overflowFlag(ovfFlag), .compareOut(cmpOut),
    .oscEnable(oscEn), .cpuStall(stall), .wakeUp(wake));
  atd_osc_model osc (.oscEnable(oscEn), .timerOscInput(oscIn));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic fail_wait();
    num_errors++;
    $display("ERROR at %0t: wait ran out", $time);
    close_out();
  endtask
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] idx, input atd_byte_t d);
    @(posedge core_clk) cpuWrite <= '{valid: 1'b1, index: idx, data: d};
    @(posedge core_clk) cpuWrite.valid <= 1'b0;
    #1;
  endtask
  // Optionally insists on silence from the comparator while it is masked
  task automatic wait_idle(input bit noMatch);
    for (n = 0; n < 300 && busy !== 5'h0; n++) begin
      step();
      if (noMatch && (busy.countBusy || busy.cmpABusy))
        chk(cmpFlag, 8'h0);
    end
    if (busy !== 5'h0) fail_wait();
  endtask

  initial begin
    num_errors = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    sleepReq = 1'b0;
    deepSleep = 1'b0;
    asyncSel = 1'b1;
    cpuWrite = '0;
    sawOvf = 1'b0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    step();
    chk(busy, 8'h0);
    wr(`ATD_IDX_COUNT, 8'h10);
    chk(busy, 8'h10);
    wr(`ATD_IDX_CMPA, 8'h20);
    chk(busy, 8'h18);
    wait_idle(1'b0);
    repeat (30) step();
    chk(cnt, 8'h10);
    wr(`ATD_IDX_COUNT, 8'h1f);
    wr(`ATD_IDX_CTLB, 8'h01);
    wait_idle(1'b1);
    prevOut = cmpOut;
    for (n = 0; n < 300 && cmpFlag !== 1'b1; n++) step();
    if (cmpFlag !== 1'b1) fail_wait();
    chk(cmpOut, !prevOut);
    @(posedge core_clk) deepSleep <= 1'b1;
    step();
    chk(oscEn, 8'h0);
    @(posedge core_clk) deepSleep <= 1'b0;
    step();
    chk(oscEn, 8'h1);
    @(posedge core_clk) sleepReq <= 1'b1;
    @(posedge core_clk) sleepReq <= 1'b0;
    for (n = 0; n < 4000 && wake !== 1'b1; n++) begin
      step();
      if (ovfFlag === 1'b1) sawOvf = 1'b1;
    end
    if (wake !== 1'b1) fail_wait();
    chk(sawOvf, 8'h1);
    for (n = 0; n < 20 && stall !== 1'b1; n++) step();
    for (n = 0; n < 20 && stall === 1'b1; n++) step();
    chk(n, `ATD_WAKE_STALL);
    close_out();
  end
endmodule

// *** atd_async_timer.sv ***
// Asynchronous timer crossing: holding registers, shadows, wake-up
`timescale 1ns/1ps
`include "atd_map.svh"
module atd_async_timer
  import atd_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire atd_write_s cpuWrite,
  input  wire logic       sleepReq,
  input  wire logic       deepSleep,
  input  wire logic       timerOscInput,
  input  wire logic       asyncClockSelect,
  output atd_busy_s       asyncStatusRegister,
  output atd_byte_t       timerCountRead,
  output logic            compareFlag,
  output logic            overflowFlag,
  output logic            compareOut,
  output logic            oscEnable,
  output logic            cpuStall,
  output logic            wakeUp
);
  wire  [`ATD_NUM_REGS-1:0] busyVec;
  wire  [`ATD_NUM_REGS-1:0] landNow;
  wire  atd_byte_t          holdVal [`ATD_NUM_REGS];
  wire  atd_byte_t          destVal [`ATD_NUM_REGS];
  atd_byte_t                count_r;
  logic                     osc1_r;
  logic                     osc2_r;
  logic                     osc3_r;
  logic [1:0]               flagPipe_r;
  logic [1:0]               flagPipe2_r;
  logic                     matchEvt_r;
  logic                     ovfEvt_r;
  logic [2:0]               stall_r;
  logic                     wakePend_r;
  atd_pwr_e                 pwr_r;
  wire                      oscRise;
  wire  [2:0]               srcSel;
  wire                      tick;
  wire                      cmpHold;
  wire                      match;
  wire                      irqEvt;
  // Oscillator is sampled by core_clk; the ratio keeps edges visible
  always_ff @(posedge core_clk) begin
    osc1_r <= timerOscInput;
    osc2_r <= osc1_r;
    osc3_r <= osc2_r;
  end
  assign oscRise = osc2_r & ~osc3_r;
  genvar g;
  generate
    for (g = 0; g < `ATD_NUM_REGS; g++) begin : g_hold
      logic       slotBusy_r;
      atd_byte_t  slotHold_r;
      atd_byte_t  slotDest_r;
      logic [1:0] slotEdges_r;
      wire        wrHit;
      assign wrHit      = cpuWrite.valid && cpuWrite.index == 3'(g);
      assign landNow[g] = slotBusy_r && oscRise &&
                          slotEdges_r == `ATD_LAND_EDGES - 2'd1;
      assign busyVec[g] = slotBusy_r;
      assign holdVal[g] = slotHold_r;
      // Each slot owns its own holding byte and edge count
      always_ff @(posedge core_clk) begin
        if (!rst_b) begin
          slotBusy_r  <= 1'b0;
          slotHold_r  <= `ATD_RST_BYTE;
          slotDest_r  <= `ATD_RST_BYTE;
          slotEdges_r <= 2'd0;
        end else if (wrHit) begin
          slotBusy_r  <= 1'b1;
          slotHold_r  <= cpuWrite.data;
          slotEdges_r <= 2'd0;
        end else if (slotBusy_r && oscRise) begin
          if (landNow[g]) begin
            slotBusy_r <= 1'b0;
            slotDest_r <= slotHold_r;
          end
          slotEdges_r <= slotEdges_r + 2'd1;
        end
      end
      // Counter slot lands in the counting register instead
      if (g == 0) begin : g_cnt
        assign destVal[g] = count_r;
      end else begin : g_dst
        assign destVal[g] = slotDest_r;
      end
    end
  endgenerate
  // Count busy is the top bit of the status word
  assign asyncStatusRegister = {busyVec[`ATD_IDX_COUNT],
                                busyVec[`ATD_IDX_CMPA],
                                busyVec[`ATD_IDX_CMPB],
                                busyVec[`ATD_IDX_CTLA],
                                busyVec[`ATD_IDX_CTLB]};
  assign srcSel  = destVal[`ATD_IDX_CTLB][`ATD_CS_MSB:`ATD_CS_LSB];
  assign tick    = oscRise && srcSel != `ATD_CS_STOP;
  assign cmpHold = busyVec[`ATD_IDX_COUNT] | busyVec[`ATD_IDX_CMPA];
  assign match   = count_r == destVal[`ATD_IDX_CMPA];
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      count_r    <= `ATD_RST_BYTE;
      matchEvt_r <= 1'b0;
      ovfEvt_r   <= 1'b0;
      compareOut <= 1'b0;
    end else begin
      matchEvt_r <= 1'b0;
      ovfEvt_r   <= 1'b0;
      if (landNow[0]) begin
        count_r <= holdVal[0];
      end else if (tick) begin
        count_r    <= count_r + 8'h01;
        ovfEvt_r   <= count_r == 8'hff;
        matchEvt_r <= match && !cmpHold;
        if (match && !cmpHold) compareOut <= ~compareOut;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) timerCountRead <= `ATD_RST_BYTE;
    else if (oscRise) timerCountRead <= count_r;
  end
  // Two crossing stages and a presenting stage: three core cycles
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      flagPipe_r   <= 2'b00;
      flagPipe2_r  <= 2'b00;
      compareFlag  <= 1'b0;
      overflowFlag <= 1'b0;
    end else begin
      flagPipe_r   <= {ovfEvt_r, matchEvt_r};
      flagPipe2_r  <= flagPipe_r;
      compareFlag  <= flagPipe2_r[0];
      overflowFlag <= flagPipe2_r[1];
    end
  end
  assign irqEvt = matchEvt_r | ovfEvt_r;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pwr_r      <= ATD_RUN;
      stall_r    <= 3'd0;
      wakePend_r <= 1'b0;
    end else begin
      if (stall_r != 3'd0) stall_r <= stall_r - 3'd1;
      case (pwr_r)
        ATD_RUN:   if (sleepReq) pwr_r <= ATD_SLEEP;
        ATD_SLEEP: begin
          // Irq held in pending resurfaces on the next oscillator rising edge
          if (irqEvt) wakePend_r <= 1'b1;
          if (wakePend_r && oscRise) begin
            pwr_r      <= ATD_WAKE;
            wakePend_r <= 1'b0;
            stall_r    <= `ATD_WAKE_STALL;
          end
        end
        ATD_WAKE:  if (stall_r == 3'd1) pwr_r <= ATD_RUN;
        default:   pwr_r <= ATD_RUN;
      endcase
    end
  end
  assign cpuStall  = stall_r != 3'd0;
  assign wakeUp    = pwr_r == ATD_WAKE;
  assign oscEnable = asyncClockSelect & ~deepSleep;
  busy_land_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    $fell(busyVec[0]) |-> $past(oscRise))
    else $error("busy cleared without oscillator edge");
  flag_delay_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    matchEvt_r |-> ##3 compareFlag)
    else $error("compare flag latency wrong");
  ovf_delay_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    ovfEvt_r |-> ##3 overflowFlag)
    else $error("overflow flag latency wrong");
  cmp_block_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    cmpHold |=> !matchEvt_r)
    else $error("match during pending write");
  stall_len_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    $rose(wakeUp) |-> cpuStall [*4] ##1 !cpuStall)
    else $error("stall not four cycles");
  wake_edge_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    $rose(wakeUp) |-> $past(oscRise))
    else $error("wake not on timer clock edge");
  stop_hold_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (srcSel == `ATD_CS_STOP && !landNow[0]) |=> $stable(count_r))
    else $error("counter moved while stopped");
  write_wins_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    landNow[0] |=> count_r == $past(holdVal[0]))
    else $error("counter write lost to count");
  shadow_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !oscRise |=> $stable(timerCountRead))
    else $error("shadow changed off edge");
  pin_domain_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    $changed(compareOut) |-> $past(tick))
    else $error("compare pin moved off timer tick");
  write_busy_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    cpuWrite.valid && cpuWrite.index < 3'd5
      |=> busyVec[$past(cpuWrite.index)])
    else $error("busy not set by write");
  osc_run_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    deepSleep |-> !oscEnable)
    else $error("oscillator on in deep sleep");
endmodule

// *** atd_map.svh ***
// Constants for the asynchronous timer domain crossing block
`ifndef ATD_MAP_SVH
`define ATD_MAP_SVH
`define ATD_NUM_REGS      5
`define ATD_IDX_COUNT     3'd0
`define ATD_IDX_CMPA      3'd1
`define ATD_IDX_CMPB      3'd2
`define ATD_IDX_CTLA      3'd3
`define ATD_IDX_CTLB      3'd4
`define ATD_CS_LSB        0
`define ATD_CS_MSB        2
`define ATD_CS_STOP       3'h0
`define ATD_RST_BYTE      8'h00
`define ATD_LAND_EDGES    2'd2
`define ATD_WAKE_STALL    3'd4
`define ATD_IRQ_CPU_SYNC  2'd3
`endif

// *** atd_osc_model.sv ***
// Timer oscillator model driving the crossing block's oscillator pin
`timescale 1ns/1ps
module atd_osc_model #(
  parameter int halfNs = 40
) (
  input  wire logic oscEnable,
  output logic      timerOscInput
);
  // Ten core cycles a period keeps well above the four-to-one floor
  initial begin
    timerOscInput = 1'b0;
    forever begin
      #halfNs;
      // Stands low while gated, as a stopped crystal would
      timerOscInput = oscEnable ? ~timerOscInput : 1'b0;
    end
  end
endmodule

// *** atd_pkg.sv ***
// Types for the asynchronous timer domain crossing block
package atd_pkg;
  typedef logic [7:0] atd_byte_t;
  typedef struct packed {
    logic      valid;
    logic [2:0] index;
    atd_byte_t data;
  } atd_write_s;
  typedef struct packed {
    logic countBusy;
    logic cmpABusy;
    logic cmpBBusy;
    logic ctlABusy;
    logic ctlBBusy;
  } atd_busy_s;
  typedef enum logic [1:0] {
    ATD_RUN   = 2'b00,
    ATD_SLEEP = 2'b01,
    ATD_WAKE  = 2'b10
  } atd_pwr_e;
endpackage
